// ### inc/oaf_pkg.sv
// shared constants and types of the octal serial output framer
package oaf_pkg;
  localparam int CH_NUM = 8;
  localparam int RES_W = 10;
  localparam int PAD_W = 2;
  localparam int WORD_W = RES_W + PAD_W;
  localparam int COARSE_W = 4;
  localparam int FINE_W = 7;
  localparam int FINE_SHIFT = 6;
  localparam logic [11:0] CORR_OFFSET = 12'h020;
  localparam logic [11:0] FULL_SCALE = 12'h3ff;
  localparam logic [4:0] LAST_PHASE = 5'h17;
  localparam logic [4:0] FRAME_HIGH = 5'h0c;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 100;
  typedef enum logic {OAF_WAIT, OAF_RUN} oaf_state_e;
endpackage

// ### core/oaf_fifo.sv
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
module oaf_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic inValid, // write request
  output logic inReady, // space available
  input wire logic [WIDTH-1:0] inData, // write word
  output logic outValid, // word available
  input wire logic outReady, // read request
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic doWrite, doRead;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];

  always_comb begin
    doWrite = inValid && inReady;
    doRead = outValid && outReady;
    wrPtr_d = doWrite ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = doRead ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage has no reset; only words counted as valid are ever read
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule // oaf_fifo

// ### core/oaf_framer.sv
// eight-channel result correction, formatting and serial framing
// Notes on behaviour
// - each 10-bit result gets two zero bits below its LSB, giving 12 bits.
// - each channel's 12-bit word leaves serially on its own differential pair.
// - all channels are sampled from one common sample clock.
// - serializer runs at 12x sample rate, locked to the sample clock.
// - a 6x bit clock and 1x frame clock leave differentially beside data.
// - bit and frame clocks come from the data's own serializing path.
// - by default the word is sent LSB first, MSB last.
// - default code runs 0 at negative full scale to 1023 at positive.
// - stage results are merged by error correction without missing codes.
// - two's complement select inverts the result MSB.
// - MSB-first order sends the MSB first and the two zeros last.
// - default order sends two zeros first, then the result LSB.
// - single-rate mode runs the bit clock at 12x, one capture edge.
`timescale 1ns/1ps
module oaf_framer import oaf_pkg::*; #(
  parameter int CHANNELS = CH_NUM,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys, // twice the serial bit rate
  input wire logic rst, // async reset, high
  input wire logic sampleClockIn, // sample clock pin
  input wire logic twosComplementSelect, // pin: two's complement output
  input wire logic msbFirstSelect, // pin: msb first order
  input wire logic singleRateEnable, // pin: single-rate bit clock
  input wire logic [CHANNELS*COARSE_W-1:0] coarseCode, // coarse stage codes
  input wire logic [CHANNELS*FINE_W-1:0] fineCode, // fine stage codes
  input wire logic resultValid, // stage codes valid
  output logic resultReady, // fifo can take codes
  output logic sampleStrobe, // common sampling pulse to all channels
  output logic frameLocked, // framing aligned to sample clock
  output logic [CHANNELS-1:0] serialDataP, // serial data, true
  output logic [CHANNELS-1:0] serialDataN, // serial data, complement
  output logic serialBitClockOutP, // bit clock, true
  output logic serialBitClockOutN, // bit clock, complement
  output logic frameClockP, // frame clock, true
  output logic frameClockN // frame clock, complement
);
  localparam int FW = CHANNELS * RES_W;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic smpMeta_q, smpSync_q, smpLast_q;
  logic [2:0] modeMeta_q, mode_q;
  logic sampleTick, twosMode, msbMode, sdrMode;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      smpMeta_q <= 1'b0;
      smpSync_q <= 1'b0;
      smpLast_q <= 1'b0;
      modeMeta_q <= 3'h0;
      mode_q <= 3'h0;
    end else begin
      smpMeta_q <= sampleClockIn;
      smpSync_q <= smpMeta_q;
      smpLast_q <= smpSync_q;
      modeMeta_q <= {singleRateEnable, msbFirstSelect, twosComplementSelect};
      mode_q <= modeMeta_q;
    end
  end

  assign sampleTick = smpSync_q && !smpLast_q;
  assign twosMode = mode_q[0];
  assign msbMode = mode_q[1];
  assign sdrMode = mode_q[2];

  // ****************************************
  // digital error correction
  // ****************************************
  logic [FW-1:0] corrected;

  for (genvar g = 0; g < CHANNELS; g++) begin : g_corr
    logic [11:0] sum;
    logic [11:0] diff;
    logic [RES_W-1:0] code;
    always_comb begin
      sum = {2'h0, coarseCode[g*COARSE_W +: COARSE_W], 6'h00} + {5'h00, fineCode[g*FINE_W +: FINE_W]};
      diff = sum - CORR_OFFSET;
      if (sum < CORR_OFFSET) begin
        code = '0;
      end else if (diff > FULL_SCALE) begin
        code = FULL_SCALE[RES_W-1:0];
      end else begin
        code = diff[RES_W-1:0];
      end
    end
    assign corrected[g*RES_W +: RES_W] = code;
  end

  // ****************************************
  // result buffer
  // ****************************************
  logic fifoValid, fifoPop;
  logic [FW-1:0] fifoData;

  oaf_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) oaf_fifo_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .inValid(resultValid),
    .inReady(resultReady),
    .inData(corrected),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // ****************************************
  // serializer
  // ****************************************
  oaf_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [WORD_W-1:0] word_q [CHANNELS];
  logic [WORD_W-1:0] word_d [CHANNELS];
  logic msbF_q, msbF_d, sdrF_q, sdrF_d, lock_q, lock_d, strobe_q;
  logic [CHANNELS-1:0] dataP_q, dataP_d;
  logic bitClk_q, bitClk_d, frame_q, frame_d;
  logic realign, load;
  logic [3:0] bitIdx, sendIdx;
  logic [RES_W-1:0] res;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    word_d = word_q;
    msbF_d = msbF_q;
    sdrF_d = sdrF_q;
    lock_d = lock_q;
    realign = 1'b0;
    load = 1'b0;
    res = '0;
    case (state_q)
      OAF_WAIT: begin
        if (sampleTick) begin
          state_d = OAF_RUN;
          cnt_d = '0;
          load = 1'b1;
        end
      end
      OAF_RUN: begin
        if (sampleTick && cnt_q != LAST_PHASE) begin
          realign = 1'b1;
        end
        if (sampleTick || cnt_q == LAST_PHASE) begin
          cnt_d = '0;
          load = 1'b1;
        end else begin
          cnt_d = cnt_q + 5'h01;
        end
      end
      default: state_d = OAF_WAIT;
    endcase
    if (realign) begin
      lock_d = 1'b0;
    end else if (sampleTick) begin
      lock_d = 1'b1;
    end
    // modes are taken only at a word boundary so a frame never mixes formats
    if (load) begin
      msbF_d = msbMode;
      sdrF_d = sdrMode;
      for (int c = 0; c < CHANNELS; c++) begin
        res = fifoValid ? fifoData[c*RES_W +: RES_W] : '0;
        res[RES_W-1] = res[RES_W-1] ^ twosMode;
        word_d[c] = {res, {PAD_W{1'b0}}};
      end
    end
    bitIdx = cnt_d[4:1];
    // lsb first by default, reversed when selected
    sendIdx = msbF_d ? 4'(WORD_W - 1) - bitIdx : bitIdx;
    for (int c = 0; c < CHANNELS; c++) begin
      dataP_d[c] = (state_d == OAF_RUN) && word_d[c][sendIdx];
    end
    // clocks from the same counter as data
    frame_d = (state_d == OAF_RUN) && (cnt_d < FRAME_HIGH);
    // ddr 6x edges mid-bit, sdr 12x rising mid-bit
    bitClk_d = (state_d == OAF_RUN) && (sdrF_d ? cnt_d[0] : (bitIdx[0] ^ cnt_d[0]));
  end

  // underflow sends an idle word rather than stalling the framing
  assign fifoPop = load;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= OAF_WAIT;
      cnt_q <= '0;
      for (int c = 0; c < CHANNELS; c++) begin
        word_q[c] <= '0;
      end
      msbF_q <= 1'b0;
      sdrF_q <= 1'b0;
      lock_q <= 1'b0;
      strobe_q <= 1'b0;
      dataP_q <= '0;
      bitClk_q <= 1'b0;
      frame_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      msbF_q <= msbF_d;
      sdrF_q <= sdrF_d;
      lock_q <= lock_d;
      strobe_q <= sampleTick;
      dataP_q <= dataP_d;
      bitClk_q <= bitClk_d;
      frame_q <= frame_d;
    end
  end

  assign sampleStrobe = strobe_q;
  assign frameLocked = lock_q;
  assign serialDataP = dataP_q;
  assign serialDataN = ~dataP_q;
  assign serialBitClockOutP = bitClk_q;
  assign serialBitClockOutN = ~bitClk_q;
  assign frameClockP = frame_q;
  assign frameClockN = ~frame_q;

  // ****************************************
  // assertions
  // ****************************************
  logic popped_q, twosAtPop_q, msbAtPop_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      popped_q <= 1'b0;
      twosAtPop_q <= 1'b0;
      msbAtPop_q <= 1'b0;
    end else begin
      popped_q <= load && fifoValid;
      twosAtPop_q <= twosMode;
      msbAtPop_q <= fifoData[RES_W-1];
    end
  end

  sequence s_zero_bits;
    (!serialDataP[0])[*4];
  endsequence
  sequence s_frame_pulse;
    frameClockP[*8] ##1 frameClockP[*4] ##1 !frameClockP;
  endsequence

  a_pad_first: assert property (@(posedge clk_sys) disable iff (rst || realign)
    $rose(frameClockP) && !msbF_q |-> s_zero_bits) else $error("pad zeros not first");
  a_pad_last: assert property (@(posedge clk_sys) disable iff (rst || realign)
    $rose(frameClockP) && msbF_q |-> ##20 s_zero_bits) else $error("pad zeros not last");
  a_frame_width: assert property (@(posedge clk_sys) disable iff (rst || realign)
    $rose(frameClockP) |-> s_frame_pulse) else $error("frame clock width wrong");
  a_ddr_bitclk: assert property (@(posedge clk_sys) disable iff (rst || realign)
    $rose(serialBitClockOutP) && !sdrF_q |=> serialBitClockOutP ##1 !serialBitClockOutP)
    else $error("ddr bit clock period wrong");
  a_sdr_bitclk: assert property (@(posedge clk_sys) disable iff (rst || realign)
    serialBitClockOutP && sdrF_q |=> !serialBitClockOutP) else $error("sdr bit clock wrong");
  a_edge_align: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(frameClockP) |-> !serialBitClockOutP ##1 serialBitClockOutP) else $error("clock edges misaligned");
  a_diff_pairs: assert property (@(posedge clk_sys) disable iff (rst)
    serialDataN == ~serialDataP && frameClockN == !frameClockP) else $error("pair not complementary");
  a_twos_msb: assert property (@(posedge clk_sys) disable iff (rst)
    popped_q |-> word_q[0][WORD_W-1] == (msbAtPop_q ^ twosAtPop_q)) else $error("msb inversion wrong");
  a_frame_lock: assert property (@(posedge clk_sys) disable iff (rst)
    sampleTick |=> cnt_q == 5'h00 && state_q == OAF_RUN) else $error("frame not locked to sample clock");
  a_corr_floor: assert property (@(posedge clk_sys) disable iff (rst)
    coarseCode[COARSE_W-1:0] == '0 && fineCode[FINE_W-1:0] < 7'h20 |-> corrected[RES_W-1:0] == '0)
    else $error("correction floor wrong");
endmodule // oaf_framer

// ### testbench/oaf_rx_model.sv
// receiver model that captures the serial lanes with the bit and frame clocks
`timescale 1ns/1ps
module oaf_rx_model import oaf_pkg::*; (
  input wire logic singleRate, // rising bit clock edges only
  input wire logic bitClk, // serial bit clock
  input wire logic frameClk, // frame clock
  input wire logic [CH_NUM-1:0] dataIn, // serial lanes
  output logic [CH_NUM*WORD_W-1:0] rxWords, // last words, first bit at 0
  output int rxFrames // words completed
);
  int idx = WORD_W;
  logic [CH_NUM*WORD_W-1:0] shiftQ = '0;
  initial rxFrames = 0;
  initial rxWords = '0;
  always @(posedge frameClk) idx = 0;
  // ddr takes both edges; bit clock edges fall mid bit, away from data changes
  always @(bitClk) begin
    if ((bitClk || !singleRate) && idx < WORD_W) begin
      for (int c = 0; c < CH_NUM; c++) shiftQ[c*WORD_W+idx] = dataIn[c];
      idx++;
      if (idx == WORD_W) begin
        rxWords = shiftQ;
        rxFrames++;
      end
    end
  end
endmodule // oaf_rx_model

// ### testbench/octal_adc_serial_output_framer_tb.sv
// self-checking bench of the octal serial output framer
`timescale 1ns/1ps
module octal_adc_serial_output_framer_tb import oaf_pkg::*;;
  logic clk_sys = 1'h0, rst = 1'h1, sampleClockIn = 1'h0, sampleRun = 1'h0;
  logic twosComplementSelect = 1'h0, msbFirstSelect = 1'h0, singleRateEnable = 1'h0, resultValid = 1'h0;
  logic [CH_NUM*COARSE_W-1:0] coarseCode = '0;
  logic [CH_NUM*FINE_W-1:0] fineCode = '0;
  logic resultReady, sampleStrobe, frameLocked, bitP, bitN, frameP, frameN;
  logic [CH_NUM-1:0] dataP, dataN;
  logic [CH_NUM*WORD_W-1:0] rxWords;
  int rxFrames, numErrors = 0, totalChecks = 0;
`define CHK(a, e, m) begin totalChecks++; if ((a) !== (e)) begin numErrors++; $display("[FAIL] %0t %s", $time, m); end end
  initial forever #(CLK_PERIOD_NS/2) clk_sys = ~clk_sys;
  // sample clock at frame rate, 24 system cycles
  initial forever begin
    @(negedge clk_sys);
    if (sampleRun) begin
      sampleClockIn = 1'h1;
      repeat (12) @(negedge clk_sys);
      sampleClockIn = 1'h0;
      repeat (11) @(negedge clk_sys);
    end
  end
  oaf_framer #(.CHANNELS(CH_NUM), .DEPTH(FIFO_DEPTH)) oaf_framer_inst (.clk_sys(clk_sys), .rst(rst),
    .sampleClockIn(sampleClockIn), .twosComplementSelect(twosComplementSelect), .msbFirstSelect(msbFirstSelect),
    .singleRateEnable(singleRateEnable), .coarseCode(coarseCode), .fineCode(fineCode), .resultValid(resultValid),
    .resultReady(resultReady), .sampleStrobe(sampleStrobe), .frameLocked(frameLocked), .serialDataP(dataP),
    .serialDataN(dataN), .serialBitClockOutP(bitP), .serialBitClockOutN(bitN), .frameClockP(frameP),
    .frameClockN(frameN));
  oaf_rx_model oaf_rx_model_inst (.singleRate(singleRateEnable), .bitClk(bitP), .frameClk(frameP),
    .dataIn(dataP), .rxWords(rxWords), .rxFrames(rxFrames));
  // expected word, k below 0 is the idle word
  function automatic logic [WORD_W-1:0] expWire(input int k, input int c, input logic tw, input logic mf);
    int s;
    logic [RES_W-1:0] r;
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] v;
    s = ((k + 3*c) % 16) * (1 << FINE_SHIFT) + (k*37 + c*19) % 128 - int'(CORR_OFFSET);
    if (k < 0 || s < 0) s = 0;
    if (s > int'(FULL_SCALE)) s = int'(FULL_SCALE);
    r = RES_W'(s);
    r[RES_W-1] = r[RES_W-1] ^ tw;
    w = {r, PAD_W'(0)};
    // msb-first arrival puts the word's top bit at index 0
    for (int i = 0; i < WORD_W; i++) v[i] = w[WORD_W-1-i];
    return mf ? v : w;
  endfunction
  task automatic wrapUp();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic pushWord(input int k);
    @(negedge clk_sys);
    for (int c = 0; c < CH_NUM; c++) begin
      coarseCode[c*COARSE_W+:COARSE_W] = COARSE_W'((k + 3*c) % 16);
      fineCode[c*FINE_W+:FINE_W] = FINE_W'((k*37 + c*19) % 128);
    end
    resultValid = 1'h1;
    while (resultReady !== 1'h1) @(negedge clk_sys);
    @(negedge clk_sys);
    resultValid = 1'h0;
  endtask
  task automatic waitFrame();
    int n;
    n = rxFrames;
    for (int i = 0; i < 60 && rxFrames == n; i++) @(negedge clk_sys);
    `CHK(rxFrames != n, 1'h1, "frame missing")
  endtask
  task automatic chkFrame(input int k, input logic tw, input logic mf);
    for (int c = 0; c < CH_NUM; c++)
      `CHK(rxWords[c*WORD_W+:WORD_W], expWire(k, c, tw, mf), "lane word")
  endtask
  task automatic countClk(output int rises, output int high, output int bad);
    logic prev;
    rises = 0;
    high = 0;
    bad = 0;
    @(posedge frameP);
    @(negedge clk_sys);
    prev = bitP;
    repeat (24) begin
      @(negedge clk_sys);
      rises += (bitP && !prev);
      high += frameP;
      bad += (dataN !== ~dataP) || (bitN !== ~bitP) || (frameN !== ~frameP);
      prev = bitP;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic testReset();
    `CHK({dataP, bitP, frameP, sampleStrobe, frameLocked}, '0, "idle low")
    `CHK({dataN, bitN, frameN, resultReady}, '1, "idle high")
    $display("reset test done");
  endtask
  task automatic testFifo();
    for (int k = 0; k < FIFO_DEPTH; k++) pushWord(k);
    @(negedge clk_sys);
    `CHK(resultReady, 1'h0, "fifo not full")
    sampleRun = 1'h1;
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      waitFrame();
      chkFrame(k, 1'h0, 1'h0);
    end
    waitFrame();
    chkFrame(-1, 1'h0, 1'h0);
    $display("fifo order test done");
  endtask
  task automatic testLock();
    int n;
    n = 0;
    `CHK(frameLocked, 1'h1, "not locked")
    repeat (240) begin
      @(negedge clk_sys);
      n += sampleStrobe;
    end
    `CHK(n, 10, "strobe count")
    sampleRun = 1'h0;
    repeat (30) @(negedge clk_sys);
    @(posedge frameP);
    repeat (5) @(negedge clk_sys);
    sampleClockIn = 1'h1;
    repeat (6) @(negedge clk_sys);
    sampleClockIn = 1'h0;
    `CHK(frameLocked, 1'h0, "lock kept")
    // let the generator see an idle step before it takes the pin back
    @(negedge clk_sys);
    sampleRun = 1'h1;
    repeat (60) @(negedge clk_sys);
    `CHK(frameLocked, 1'h1, "no relock")
    $display("lock test done");
  endtask
  task automatic testSdr();
    int r, h, b;
    countClk(r, h, b);
    `CHK(r, 6, "ddr bit clock")
    `CHK(h, 12, "frame clock")
    `CHK(b, 0, "pair polarity")
    singleRateEnable = 1'h1;
    repeat (5) @(negedge clk_sys);
    countClk(r, h, b);
    `CHK(r, 12, "sdr bit clock")
    $display("bit clock test done");
  endtask
  task automatic testModes();
    twosComplementSelect = 1'h1;
    msbFirstSelect = 1'h1;
    repeat (3) waitFrame();
    chkFrame(-1, 1'h1, 1'h1);
    pushWord(5);
    for (int i = 0; i < 3 && rxWords[WORD_W-1:0] === expWire(-1, 0, 1'h1, 1'h1); i++) waitFrame();
    chkFrame(5, 1'h1, 1'h1);
    $display("format mode test done");
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    testReset();
    rst = 1'h0;
    testFifo();
    testLock();
    testSdr();
    testModes();
    wrapUp();
  end
  // run needs about 1000 cycles
  initial begin
    #(CLK_PERIOD_NS * 5000);
    numErrors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrapUp();
  end
endmodule // octal_adc_serial_output_framer_tb
